// >>> core/scf_pkg.sv
package scf_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCL_PERIOD_NS = 1000;
    // each serial clock period is four quarters; least time, round up
    localparam int QTR_CYC =
        (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
    localparam int QTR_W = 6;
    localparam logic [QTR_W-1:0] QTR_LAST = QTR_W'(QTR_CYC - 1);
    localparam int STARTUP_PULSES = 5;
    // a whole byte of pulses covers the required minimum
    localparam int DUMMY_PULSES = (STARTUP_PULSES > 8) ? STARTUP_PULSES : 8;
    localparam logic [3:0] DUMMY_LAST = 4'(DUMMY_PULSES - 1);

    // ------------------------------------------------------------------
    // command encodings
    // ------------------------------------------------------------------
    localparam logic [3:0] DEV_ADDR_STD = 4'hB;
    localparam logic [3:0] OP_WR_USER   = 4'h0;
    localparam logic [3:0] OP_RD_USER   = 4'h2;
    localparam logic [3:0] OP_SYS_WR    = 4'h4;
    localparam logic [3:0] OP_SYS_RD    = 4'h6;
    localparam logic [3:0] OP_VERIFY    = 4'h8;
    localparam logic [3:0] OP_PASSWD    = 4'hA;
    localparam logic [7:0] SW_CFG       = 8'h00;
    localparam logic [7:0] SW_FUSE      = 8'h01;
    localparam logic [7:0] SW_CKSUM     = 8'h02;
    localparam logic [7:0] SW_ZONE      = 8'h03;
    localparam logic [7:0] SW_CFG_AT    = 8'h08;
    localparam logic [7:0] SW_ZONE_AT   = 8'h0B;
    localparam logic [7:0] SR_CFG       = 8'h00;
    localparam logic [7:0] SR_FUSE      = 8'h01;
    localparam logic [7:0] SR_CKSUM     = 8'h02;
    localparam logic [7:0] CNT_NONE     = 8'h00;
    localparam logic [7:0] CNT_FUSE_RD  = 8'h01;
    localparam logic [7:0] CNT_CKSUM    = 8'h02;
    localparam logic [7:0] CNT_PASSWD   = 8'h03;
    localparam logic [7:0] CNT_AT_MAX   = 8'h08;
    localparam logic [7:0] CNT_VERIFY   = 8'h10;
    localparam logic [7:0] CNT_WR_MAX   = 8'h80;
    localparam logic [8:0] READ_ZERO_LEN = 9'h100;
    localparam logic [3:0] MODE_NIB_MAX = 4'h1;
    localparam logic [3:0] KEYSET_MAX   = 4'h3;
    localparam logic [3:0] PWSET_MAX    = 4'h7;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] addr1;
        logic [7:0] addr2;
        logic [7:0] count;
    } scf_cmd_t;

    typedef struct packed {
        logic bad_cmd;
        logic nack;
    } scf_rsp_t;

    typedef enum logic [10:0] {
        ST_DUMMY  = 11'h001,
        ST_IDLE   = 11'h002,
        ST_START  = 11'h004,
        ST_TXBIT  = 11'h008,
        ST_TXACK  = 11'h010,
        ST_WAITW  = 11'h020,
        ST_RXBIT  = 11'h040,
        ST_RXPUSH = 11'h080,
        ST_RXACK  = 11'h100,
        ST_STOP   = 11'h200,
        ST_SPARE  = 11'h400
    } scf_state_t;

endpackage

// >>> core/scf_sync3.sv
`timescale 1ns/10ps

module scf_sync3
    import scf_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // pin side
    input  wire logic din,
    // filtered level
    output logic      dout
);

    typedef struct packed {
        logic ff1;
        logic ff2;
        logic ff3;
        logic out;
    } scf_sync_st_t;

    scf_sync_st_t s_reg;
    scf_sync_st_t s_next;

    // released bus idles high, so every stage resets high
    always_comb
    begin
        s_next     = s_reg;
        s_next.ff1 = din;
        s_next.ff2 = s_reg.ff1;
        s_next.ff3 = s_reg.ff2;
        if (s_reg.ff2 == s_reg.ff3)
        begin
            s_next.out = s_reg.ff3;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_reg <= '{ff1: 1'b1, ff2: 1'b1, ff3: 1'b1, out: 1'b1};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign dout = s_reg.out;

endmodule

// >>> core/scf_buf2.sv
`timescale 1ns/10ps

module scf_buf2
    import scf_pkg::*;
#(
    parameter int W = 8
)
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);

    typedef struct packed {
        logic [W-1:0] e0;
        logic [W-1:0] e1;
        logic [1:0]   cnt;
    } scf_buf_st_t;

    scf_buf_st_t b_reg;
    scf_buf_st_t b_next;
    logic        push;
    logic        pop;

    assign in_ready  = (b_reg.cnt != 2'h2);
    assign out_valid = (b_reg.cnt != 2'h0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    // head always sits in e0 so the output is a flop, not a mux
    assign out_data  = b_reg.e0;

    always_comb
    begin
        b_next = b_reg;
        if (push && !pop)
        begin
            if (b_reg.cnt == 2'h0)
            begin
                b_next.e0 = in_data;
            end
            else
            begin
                b_next.e1 = in_data;
            end
            b_next.cnt = b_reg.cnt + 2'h1;
        end
        else if (pop && !push)
        begin
            b_next.e0  = b_reg.e1;
            b_next.cnt = b_reg.cnt - 2'h1;
        end
        else if (pop && push)
        begin
            if (b_reg.cnt == 2'h1)
            begin
                b_next.e0 = in_data;
            end
            else
            begin
                b_next.e0 = b_reg.e1;
                b_next.e1 = in_data;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            b_reg <= '0;
        end
        else
        begin
            b_reg <= b_next;
        end
    end

endmodule

// >>> core/scf_host.sv
`timescale 1ns/10ps

module scf_host
    import scf_pkg::*;
#(
    parameter logic [7:0] PAGE_MAX     = 8'h10,
    parameter logic [3:0] ALT_DEV_ADDR = 4'hF
)
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // command request
    input  wire logic       cmd_valid,
    output logic            cmd_ready,
    input  wire scf_cmd_t   cmd,
    // write data stream
    input  wire logic       wr_valid,
    output logic            wr_ready,
    input  wire logic [7:0] wr_data,
    // read data stream
    output logic            rd_valid,
    input  wire logic       rd_ready,
    output logic [7:0]      rd_data,
    // completion
    output logic            rsp_valid,
    output scf_rsp_t        rsp,
    output logic            at_mode,
    // serial pins
    output logic            scl_o,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        scf_state_t       st;
        logic [QTR_W-1:0] qcnt;
        logic [1:0]       qtr;
        logic [3:0]       bitcnt;
        logic [7:0]       shreg;
        logic [8:0]       remain;
        logic [1:0]       hidx;
        scf_cmd_t         cmd;
        logic             is_read;
        logic             scl;
        logic             sda_low;
        logic             at;
        logic             nack;
        logic             rsp_v;
        scf_rsp_t         rsp;
    } scf_host_st_t;

    scf_host_st_t r_reg;
    scf_host_st_t r_next;
    logic         sda_s;
    logic         fifo_in_ready;
    logic         timed;
    logic         tick;
    logic         q_end;
    logic         last_q;
    logic         samp;
    logic         rd_cmd;
    logic [8:0]   new_len;

    // ------------------------------------------------------------------
    // command check
    // ------------------------------------------------------------------
    function automatic logic cmd_ok(scf_cmd_t c, logic at);
        logic [7:0] wmax;
        logic       ok;
        logic       rd;
        wmax = at ? CNT_AT_MAX : PAGE_MAX;
        ok   = 1'b0;
        rd   = (c.opcode[3:0] == OP_RD_USER) ||
               (c.opcode[3:0] == OP_SYS_RD);
        if (!c.opcode[0] &&
            ((c.opcode[7:4] == DEV_ADDR_STD) ||
             (c.opcode[7:4] == ALT_DEV_ADDR)))
        begin
            case (c.opcode[3:0])
                OP_WR_USER: ok = (c.count <= wmax);
                OP_RD_USER: ok = 1'b1;
                OP_SYS_WR:
                begin
                    case (c.addr1)
                        SW_CFG:     ok = (c.count <= PAGE_MAX);
                        SW_FUSE:    ok = (c.count == CNT_NONE);
                        SW_CKSUM:   ok = (c.count == CNT_CKSUM);
                        SW_ZONE:    ok = (c.count == CNT_NONE);
                        SW_CFG_AT:  ok = (c.count <= CNT_AT_MAX);
                        SW_ZONE_AT: ok = (c.count == CNT_NONE);
                        default:    ok = 1'b0;
                    endcase
                end
                OP_SYS_RD:
                begin
                    case (c.addr1)
                        SR_CFG:   ok = 1'b1;
                        SR_FUSE:  ok = (c.count == CNT_FUSE_RD);
                        SR_CKSUM: ok = (c.count == CNT_CKSUM);
                        default:  ok = 1'b0;
                    endcase
                end
                OP_VERIFY:
                    ok = (c.addr1[7:4] <= MODE_NIB_MAX) &&
                         (c.addr1[3:0] <= KEYSET_MAX) &&
                         (c.count == CNT_VERIFY);
                OP_PASSWD:
                    ok = (c.addr1[7:4] <= MODE_NIB_MAX) &&
                         (c.addr1[3:0] <= PWSET_MAX) &&
                         (c.count == CNT_PASSWD);
                default: ok = 1'b0;
            endcase
        end
        return ok && (rd || (c.count <= CNT_WR_MAX));
    endfunction

    assign rd_cmd = (cmd.opcode[3:0] == OP_RD_USER) ||
                    (cmd.opcode[3:0] == OP_SYS_RD);
    assign new_len = ((cmd.opcode[3:0] == OP_RD_USER) &&
                      (cmd.count == CNT_NONE)) ?
                     READ_ZERO_LEN : {1'b0, cmd.count};

    // ------------------------------------------------------------------
    // quarter-period timing
    // ------------------------------------------------------------------
    assign timed = (r_reg.st == ST_DUMMY) || (r_reg.st == ST_START) ||
                   (r_reg.st == ST_TXBIT) || (r_reg.st == ST_TXACK) ||
                   (r_reg.st == ST_RXBIT) || (r_reg.st == ST_RXACK) ||
                   (r_reg.st == ST_STOP);
    assign tick   = (r_reg.qcnt == QTR_LAST);
    assign q_end  = timed && tick;
    assign last_q = q_end && (r_reg.qtr == 2'h3);
    assign samp   = q_end && (r_reg.qtr == 2'h2);

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    always_comb
    begin
        r_next       = r_reg;
        r_next.rsp_v = 1'b0;
        if (timed)
        begin
            r_next.qcnt = tick ? '0 : r_reg.qcnt + 1'b1;
        end
        if (q_end)
        begin
            r_next.qtr = r_reg.qtr + 2'h1;
            // bit data moves in the middle of the low phase, the read ack at its start from ST_RXPUSH; start and stop change it while the clock is high
            if (r_reg.qtr == 2'h0)
            begin
                case (r_reg.st)
                    ST_TXBIT: r_next.sda_low = ~r_reg.shreg[7];
                    ST_TXACK: r_next.sda_low = 1'b0;
                    ST_RXBIT: r_next.sda_low = 1'b0;
                    ST_STOP:  r_next.sda_low = 1'b1;
                    default:  r_next.sda_low = r_reg.sda_low;
                endcase
            end
            if (r_reg.qtr == 2'h1)
            begin
                if (r_reg.st == ST_START)
                begin
                    r_next.sda_low = 1'b1;
                end
                else
                begin
                    r_next.scl = 1'b1;
                end
            end
            if ((r_reg.qtr == 2'h3) && (r_reg.st != ST_STOP))
            begin
                r_next.scl = 1'b0;
            end
        end

        case (r_reg.st)
            ST_DUMMY:
            begin
                // data stays released; the device sees only pulses
                if (last_q)
                begin
                    r_next.bitcnt = r_reg.bitcnt + 4'h1;
                    if (r_reg.bitcnt == DUMMY_LAST)
                    begin
                        r_next.bitcnt = 4'h0;
                        r_next.scl    = 1'b1;
                        r_next.st     = ST_IDLE;
                    end
                end
            end
            ST_IDLE:
            begin
                if (cmd_valid)
                begin
                    if (cmd_ok(cmd, r_reg.at))
                    begin
                        r_next.cmd     = cmd;
                        r_next.shreg   = cmd.opcode;
                        r_next.hidx    = 2'h0;
                        r_next.remain  = new_len;
                        r_next.is_read = rd_cmd;
                        r_next.nack    = 1'b0;
                        r_next.st      = ST_START;
                    end
                    else
                    begin
                        r_next.rsp_v = 1'b1;
                        r_next.rsp   = '{bad_cmd: 1'b1, nack: 1'b0};
                    end
                end
            end
            ST_START:
            begin
                if (last_q)
                begin
                    r_next.st = ST_TXBIT;
                end
            end
            ST_TXBIT:
            begin
                if (last_q)
                begin
                    r_next.shreg  = {r_reg.shreg[6:0], 1'b0};
                    r_next.bitcnt = r_reg.bitcnt + 4'h1;
                    if (r_reg.bitcnt == 4'h7)
                    begin
                        r_next.bitcnt = 4'h0;
                        r_next.st     = ST_TXACK;
                    end
                end
            end
            ST_TXACK:
            begin
                if (samp)
                begin
                    r_next.nack = sda_s;
                end
                if (last_q)
                begin
                    if (r_reg.nack)
                    begin
                        r_next.st = ST_STOP;
                    end
                    else if (r_reg.hidx != 2'h3)
                    begin
                        r_next.hidx = r_reg.hidx + 2'h1;
                        case (r_reg.hidx)
                            2'h0:    r_next.shreg = r_reg.cmd.addr1;
                            2'h1:    r_next.shreg = r_reg.cmd.addr2;
                            default: r_next.shreg = r_reg.cmd.count;
                        endcase
                        r_next.st = ST_TXBIT;
                    end
                    else if (r_reg.remain == 9'h000)
                    begin
                        r_next.st = ST_STOP;
                    end
                    else if (r_reg.is_read)
                    begin
                        r_next.st = ST_RXBIT;
                    end
                    else
                    begin
                        r_next.st = ST_WAITW;
                    end
                end
            end
            ST_WAITW:
            begin
                // clock is held low while the source has nothing ready
                if (wr_valid)
                begin
                    r_next.shreg  = wr_data;
                    r_next.remain = r_reg.remain - 9'h001;
                    r_next.st     = ST_TXBIT;
                end
            end
            ST_RXBIT:
            begin
                if (samp)
                begin
                    r_next.shreg = {r_reg.shreg[6:0], sda_s};
                end
                if (last_q)
                begin
                    r_next.bitcnt = r_reg.bitcnt + 4'h1;
                    if (r_reg.bitcnt == 4'h7)
                    begin
                        r_next.bitcnt = 4'h0;
                        r_next.st     = ST_RXPUSH;
                    end
                end
            end
            ST_RXPUSH:
            begin
                // a full buffer stalls the clock, so no byte is lost
                if (fifo_in_ready)
                begin
                    r_next.remain  = r_reg.remain - 9'h001;
                    r_next.sda_low = (r_reg.remain != 9'h001);
                    r_next.st      = ST_RXACK;
                end
            end
            ST_RXACK:
            begin
                if (last_q)
                begin
                    r_next.st = (r_reg.remain == 9'h000) ?
                                ST_STOP : ST_RXBIT;
                end
            end
            ST_STOP:
            begin
                if (last_q)
                begin
                    r_next.sda_low = 1'b0;
                    r_next.st      = ST_IDLE;
                    r_next.rsp_v   = 1'b1;
                    r_next.rsp     = '{bad_cmd: 1'b0, nack: r_reg.nack};
                    if (!r_reg.nack &&
                        (r_reg.cmd.opcode[3:0] == OP_SYS_WR))
                    begin
                        if (r_reg.cmd.addr1 == SW_ZONE)
                        begin
                            r_next.at = 1'b0;
                        end
                        if (r_reg.cmd.addr1 == SW_ZONE_AT)
                        begin
                            r_next.at = 1'b1;
                        end
                    end
                end
            end
            default:
            begin
                r_next.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            r_reg    <= '0;
            r_reg.st <= ST_DUMMY;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------------
    // pins and streams
    // ------------------------------------------------------------------
    scf_sync3 u_sda_sync (
        .clk  (clk),
        .rst  (rst),
        .din  (sda_i),
        .dout (sda_s)
    );

    scf_buf2 #(
        .W (8)
    ) u_rd_buf (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (r_reg.st == ST_RXPUSH),
        .in_ready  (fifo_in_ready),
        .in_data   (r_reg.shreg),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data)
    );

    assign cmd_ready = (r_reg.st == ST_IDLE);
    assign wr_ready  = (r_reg.st == ST_WAITW);
    assign rsp_valid = r_reg.rsp_v;
    assign rsp       = r_reg.rsp;
    assign at_mode   = r_reg.at;
    assign scl_o     = r_reg.scl;
    // open drain: only ever pulls low
    assign sda_o     = 1'b0;
    assign sda_oe    = r_reg.sda_low;

endmodule

// >>> sim/scf_host_props.sv
`timescale 1ns/10ps

module scf_host_props
    import scf_pkg::*;
#(
    parameter logic [7:0] PAGE_MAX     = 8'h10,
    parameter logic [3:0] ALT_DEV_ADDR = 4'hF
)
(
    // clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // command side
    input wire logic       cmd_valid,
    input wire logic       cmd_ready,
    input wire scf_cmd_t   cmd,
    input wire logic       wr_ready,
    input wire logic       rd_valid,
    input wire logic       rd_ready,
    input wire logic [7:0] rd_data,
    input wire logic       rsp_valid,
    input wire scf_rsp_t   rsp,
    // serial pins
    input wire logic       scl_o,
    input wire logic       sda_oe
);
    wire take = cmd_valid && cmd_ready;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    chk_bad_lsb: assert property (take && cmd.opcode[0] |=>
        rsp_valid && rsp.bad_cmd) else $error("odd opcode taken");
    chk_bad_devaddr: assert property (take &&
        cmd.opcode[7:4] != 4'hB && cmd.opcode[7:4] != ALT_DEV_ADDR
        |=> rsp_valid && rsp.bad_cmd) else $error("foreign address taken");
    chk_bad_quiet: assert property (take && cmd.opcode[0] |=>
        (scl_o && !sda_oe) [*3]) else $error("bus moved on refusal");
    chk_idle_bus: assert property (cmd_ready |-> scl_o && !sda_oe)
        else $error("bus busy while idle");
    chk_wr_wait: assert property (wr_ready |-> !scl_o)
        else $error("clock ran without data");
    chk_rd_hold: assert property (rd_valid && !rd_ready |=>
        rd_valid && $stable(rd_data)) else $error("read byte lost");
    chk_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
        else $error("response too long");
    chk_startup: assert property ($fell(rst) |-> !cmd_ready [*8])
        else $error("command taken during start-up");

    cov_rd_pop: cover property (rd_valid && rd_ready);
    cov_rd_full: cover property (rd_valid && !rd_ready && scl_o == 1'b0);
    cov_nack: cover property (rsp_valid && rsp.nack);
endmodule

bind scf_host scf_host_props #(.PAGE_MAX(PAGE_MAX),
    .ALT_DEV_ADDR(ALT_DEV_ADDR)) u_props (.*);

// >>> sim/scf_dev_model.sv
`timescale 1ns/10ps

module scf_dev_model
(
    // host reset
    input  wire logic rst,
    // serial pins
    input  wire logic scl,
    input  wire logic sda,
    // fault control
    input  wire logic nak,
    output logic      dev_oe
);
    logic [7:0] sh, op, tx;
    logic [7:0] got [16];
    logic       up = 1'b0;
    logic       rd = 1'b0;
    int         bc = 0;
    int         nb = 0;
    initial dev_oe = 1'b0;

    // a host reset abandons the frame; drop it so the line is released
    always @(posedge rst)
    begin
        up = 1'b0;
        rd = 1'b0;
        dev_oe = 1'b0;
    end

    // start-up pulses are ignored until the first start
    always @(negedge sda)
        if (scl)
        begin
            up = 1'b1;
            bc = -1;
            nb = 0;
            rd = 1'b0;
            tx = 8'h5A;
        end
    always @(posedge scl)
    begin
        sh = {sh[6:0], sda};
        if (rd && bc == 8 && sda) rd = 1'b0;
    end
    always @(negedge scl)
        if (up)
        begin
            bc = (bc == 8) ? 0 : bc + 1;
            if (bc == 8 && rd) tx = tx + 8'h01;
            if (bc == 8 && !rd)
            begin
                got[nb] = sh;
                nb = nb + 1;
                if (nb == 1) op = sh;
            end
            dev_oe = (bc == 8) ? !rd && !nak : rd && !tx[7-bc];
            if (bc == 8 && nb == 4 && op[1] && !op[3]) rd = 1'b1;
        end
endmodule

// >>> sim/scf_host_tb.sv
`timescale 1ns/10ps

module scf_host_tb;
    import scf_pkg::*;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       cmd_valid = 1'b0;
    logic       wr_valid = 1'b0;
    logic       rd_ready = 1'b0;
    logic       nak = 1'b0;
    scf_cmd_t   cmd = '0;
    logic [7:0] wr_data = 8'h00;
    logic [7:0] rd_data;
    scf_rsp_t   rsp, r;
    logic       cmd_ready, wr_ready, rd_valid, rsp_valid, at_mode;
    logic       scl_o, sda_o, sda_oe, dev_oe;
    wire        sda_i = !(sda_oe || dev_oe);
    int         fail_count = 0;
    int         checks = 0;
    int         cyc = 0;
    logic [7:0] q [$];

    always #5 clk = ~clk;
    scf_host uut (.*);
    scf_dev_model dev (.rst(rst), .scl(scl_o), .sda(sda_i), .nak(nak),
        .dev_oe(dev_oe));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // reads stall for a while so the two-entry buffer fills
    task automatic xfer(input scf_cmd_t c);
        int n;
        n = 0;
        q.delete();
        @(posedge clk);
        cmd <= c;
        cmd_valid <= 1'b1;
        wr_data <= 8'hC0;
        wr_valid <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
            if (cmd_ready === 1'b1) cmd_valid <= 1'b0;
            if (wr_valid && wr_ready) wr_data <= wr_data + 8'h01;
            if (rd_valid && rd_ready) q.push_back(rd_data);
            rd_ready <= n > 7000;
        end
        while (rsp_valid !== 1'b1 && n < 20000);
        if (rsp_valid !== 1'b1)
        begin
            fail_count++;
            summarize();
        end
        r = rsp;
        wr_valid <= 1'b0;
        // bytes still buffered at the response are drained here
        repeat (3)
        begin
            @(posedge clk);
            if (rd_valid && rd_ready) q.push_back(rd_data);
            rd_ready <= 1'b1;
        end
    endtask
    task automatic t_write;
        logic [7:0] e [7] = '{8'hB0, 8'h12, 8'h34, 8'h03, 8'hC0, 8'hC1,
            8'hC2};
        xfer(32'hB0123403);
        chk(8'(r), 8'h00);
        for (int i = 0; i < 7; i++) chk(dev.got[i], e[i]);
        chk(8'(sda_o), 8'h00);
        xfer(32'hBA170003);
        chk(8'(r), 8'h00);
        chk(dev.got[6], 8'hC2);
        $display("write test done");
    endtask
    task automatic t_read;
        xfer(32'hB2001003);
        chk(8'(q.size()), 8'h03);
        for (int i = 0; i < 3; i++) chk(q[i], 8'(8'h5A + i));
        xfer(32'hF6010001);
        chk(8'(q.size()), 8'h01);
        $display("read test done");
    endtask
    // a zero count read runs far longer; a reset then abandons it
    task automatic t_long;
        q.delete();
        @(posedge clk);
        cmd <= 32'hB2000000;
        cmd_valid <= 1'b1;
        repeat (8000)
        begin
            @(posedge clk);
            if (cmd_ready === 1'b1) cmd_valid <= 1'b0;
            if (rd_valid && rd_ready) q.push_back(rd_data);
        end
        chk(8'(q.size()), 8'h04);
        chk(q[3], 8'h5D);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 2000 && cmd_ready !== 1'b1; i++) @(posedge clk);
        chk(8'(cmd_ready), 8'h01);
        $display("long read and reset test done");
    endtask
    task automatic t_bad;
        scf_cmd_t b [7] = '{32'hB1000000, 32'hC2000001, 32'hB0000011,
            32'hB4020001, 32'hB8200010, 32'hBA080003, 32'hB6030001};
        foreach (b[i])
        begin
            xfer(b[i]);
            chk(8'(r.bad_cmd), 8'h01);
        end
        $display("refusal test done");
    endtask
    task automatic t_zone;
        xfer(32'hB40B0500);
        @(posedge clk);
        chk(8'(at_mode), 8'h01);
        xfer(32'hB0000009);
        chk(8'(r.bad_cmd), 8'h01);
        xfer(32'hB4030500);
        @(posedge clk);
        chk(8'(at_mode), 8'h00);
        nak <= 1'b1;
        xfer(32'hB0000002);
        chk(8'(r), 8'h01);
        nak <= 1'b0;
        $display("zone and nack test done");
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            fail_count++;
            summarize();
        end
    end
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 2000 && cmd_ready !== 1'b1; i++) @(posedge clk);
        t_write();
        t_read();
        t_long();
        t_bad();
        t_zone();
        summarize();
    end
endmodule
